// >>> design/cxbs_pkg.sv
// Package for the transmit buffer select block
package cxbs_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_SELECTOR  = 8'h00;
   localparam logic [7:0] ADDR_FLAGS     = 8'h04;
   localparam logic [7:0] ADDR_ACC_CTRL  = 8'h08;
   localparam logic [7:0] ADDR_WIN_BASE  = 8'h40;
   localparam logic [7:0] ADDR_WIN_LAST  = 8'h7C;
   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int         NUM_BUF        = 3;
   localparam int         WIN_WORDS      = 16;
   localparam int         HIT_LSB        = 0;
   localparam int         HIT_W          = 3;
   localparam logic [7:0] HIT_MASK       = 8'h07;
   localparam logic [7:0] SELECTOR_RST   = 8'h00;
   localparam logic [7:0] ACC_CTRL_RST   = 8'h00;
endpackage : cxbs_pkg

// >>> design/cxbs_top.sv
// Transmit buffer select, foreground window and acceptance control registers
//
// The implementer's own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
// Behaviour
// - Selector held at reset while init request and acknowledge are both high.
// - Selector writes accepted only when request and acknowledge are both low.
// - Three select bits; lowest set bit picks the windowed buffer.
// - Zero deselects a buffer; one selects it only if no lower bit set.
// - Selector reads show only the lowest set bit of the written value.
// - Window blocked while selected buffer not empty and scheduled for sending.
// - No buffer selected means no window access at all.
// - Acceptance control written only in init mode; readable any time.
// - Filter hit indicator bits are read-only, even in init mode.
module cxbs_top #(
   parameter int NB = cxbs_pkg::NUM_BUF,
   parameter int NW = cxbs_pkg::WIN_WORDS
) (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic               pready,
   output logic [31:0]        prdata,
   output logic               pslverr,
   input  wire logic          init_request,
   input  wire logic          init_acknowledge,
   input  wire logic [NB-1:0] buf_free,
   input  wire logic [NB-1:0] buf_scheduled,
   input  wire logic [2:0]    filter_hit_in,
   output logic [NB-1:0]      buffer_empty_flag,
   output logic [NB-1:0]      fg_select,
   output logic [7:0]         acceptance_control
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0]    sel;
      logic [7:0]    acc;
      logic [31:0]   rdata;
      logic          err;
      logic [NB-1:0][NW-1:0][31:0] mem;
   } cxbs_state_s;

   cxbs_state_s state_reg;
   cxbs_state_s state_next;

   logic [NB-1:0] onehot;
   logic [NB:0]   below;
   logic [1:0]    idx_chain [NB+1];
   logic          in_init;
   logic          out_init;
   logic          setup;
   logic          access;
   logic          sel_hit;
   logic          flag_hit;
   logic          acc_hit;
   logic          win_hit;
   logic          win_ok;
   logic [3:0]    widx;
   logic [1:0]    bidx;
   logic [31:0]   rd_value;
   logic          rd_error;

   // ****************************************
   // Selection
   // ****************************************
   assign below[0]     = 1'b0;
   assign idx_chain[0] = 2'h0;

   for (genvar g = 0; g < NB; g++) begin : g_sel
      assign onehot[g]      = state_reg.sel[g] & ~below[g];
      assign below[g+1]     = below[g] | state_reg.sel[g];
      assign idx_chain[g+1] = onehot[g] ? 2'(g) : idx_chain[g];
   end

   assign bidx = idx_chain[NB];

   // ****************************************
   // Decode
   // ****************************************
   assign in_init  = init_request & init_acknowledge;
   assign out_init = ~init_request & ~init_acknowledge;
   assign setup    = psel & ~penable;
   assign access   = psel & penable;
   assign sel_hit  = (paddr == cxbs_pkg::ADDR_SELECTOR);
   assign flag_hit = (paddr == cxbs_pkg::ADDR_FLAGS);
   assign acc_hit  = (paddr == cxbs_pkg::ADDR_ACC_CTRL);
   assign win_hit  = (paddr >= cxbs_pkg::ADDR_WIN_BASE) && (paddr <= cxbs_pkg::ADDR_WIN_LAST)
                     && (paddr[1:0] == 2'h0);
   assign widx     = paddr[5:2];
   assign win_ok   = (|onehot) && !(~buf_free[bidx] && buf_scheduled[bidx]);

   // ****************************************
   // Read data
   // ****************************************
   always_comb begin
      rd_value = 32'h0000_0000;
      rd_error = 1'b0;
      if (sel_hit) begin
         rd_value = 32'(onehot);
      end else if (flag_hit) begin
         rd_value = 32'(buf_free);
      end else if (acc_hit) begin
         rd_value = {24'h00_0000, state_reg.acc[7:3], filter_hit_in};
      end else if (win_hit) begin
         if (!win_ok) begin
            rd_error = 1'b1;
         end else begin
            rd_value = state_reg.mem[bidx][widx];
         end
      end else begin
         rd_error = 1'b1;
      end
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      state_next = state_reg;
      if (setup) begin
         state_next.rdata = rd_value;
         state_next.err   = rd_error;
      end
      if (access && pwrite) begin
         if (sel_hit) begin
            if (out_init) begin
               state_next.sel = 8'(pwdata[NB-1:0]);
            end
         end else if (acc_hit) begin
            if (in_init) begin
               state_next.acc = pwdata[7:0] & ~cxbs_pkg::HIT_MASK;
            end
         end else if (win_hit && win_ok && !state_reg.err) begin
            state_next.mem[bidx][widx] = pwdata;
         end
      end
      if (in_init) begin
         state_next.sel = cxbs_pkg::SELECTOR_RST;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg     <= '0;
         state_reg.sel <= cxbs_pkg::SELECTOR_RST;
         state_reg.acc <= cxbs_pkg::ACC_CTRL_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign pready             = 1'b1;
   assign prdata             = state_reg.rdata;
   assign pslverr            = state_reg.err & access;
   assign buffer_empty_flag  = buf_free;
   assign fg_select          = onehot;
   assign acceptance_control = {state_reg.acc[7:3], filter_hit_in};

   // ****************************************
   // Checks on selection
   // ****************************************
   a_sel_init_hold: assert property (@(posedge pclk) disable iff (!presetn)
      in_init |=> state_reg.sel == 8'h00)
      else $error("selector not held in init");

   a_fg_init_clear: assert property (@(posedge pclk) disable iff (!presetn)
      in_init |=> fg_select == '0)
      else $error("buffer still mapped in init");

   a_sel_write_gate: assert property (@(posedge pclk) disable iff (!presetn)
      (!out_init && !in_init) |=> state_reg.sel == $past(state_reg.sel))
      else $error("selector changed outside normal mode");

   a_sel_write_take: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && sel_hit && out_init) |=> state_reg.sel[2:0] == $past(pwdata[2:0]))
      else $error("selector write lost");

   a_sel_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!access && !in_init) |=> state_reg.sel == $past(state_reg.sel))
      else $error("selector changed without a write");

   a_sel_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg.sel[7:3] == 5'h00)
      else $error("selector upper bits stored");

   a_sel_onehot: assert property (@(posedge pclk) disable iff (!presetn)
      $onehot0(onehot))
      else $error("foreground select not one-hot");

   a_sel_lowest: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg.sel[0] |-> onehot == 3'b001)
      else $error("lowest bit not chosen");

   a_sel_middle: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg.sel[1:0] == 2'b10) |-> onehot == 3'b010)
      else $error("middle bit not chosen");

   a_sel_top: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg.sel[2:0] == 3'b100) |-> onehot == 3'b100)
      else $error("top bit not chosen");

   a_sel_none: assert property (@(posedge pclk) disable iff (!presetn)
      (state_reg.sel[2:0] == 3'b000) |-> onehot == 3'b000)
      else $error("buffer mapped without select");

   a_sel_readback: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && sel_hit) |-> prdata[2:0] == $past(onehot))
      else $error("selector readback wrong");

   a_sel_read_high: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && sel_hit) |-> prdata[31:3] == 29'h0000_0000)
      else $error("selector readback upper bits set");

   a_sel_read_ok: assert property (@(posedge pclk) disable iff (!presetn)
      (access && sel_hit) |-> !pslverr)
      else $error("selector access refused");

   // ****************************************
   // Checks on the window
   // ****************************************
   a_win_busy: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && win_hit && |onehot && !buf_free[bidx] && buf_scheduled[bidx]) |=> pslverr)
      else $error("busy buffer accessed");

   a_win_free: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && win_hit && win_ok) |=> !pslverr)
      else $error("free buffer refused");

   a_win_write_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && win_hit && pslverr) |=> state_reg.mem == $past(state_reg.mem))
      else $error("refused window write landed");

   a_win_write_land: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && win_hit && win_ok && !pslverr)
      |=> state_reg.mem[$past(bidx)][$past(widx)] == $past(pwdata))
      else $error("window write lost");

   a_win_none: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && win_hit && onehot == '0) |=> pslverr)
      else $error("window open without select");

   a_win_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && win_hit && pslverr) |-> prdata == 32'h0000_0000)
      else $error("refused window read returned data");

   a_win_fg_empty: assert property (@(posedge pclk) disable iff (!presetn)
      (fg_select == '0) |-> !win_ok)
      else $error("window usable without select");

   // ****************************************
   // Checks on acceptance control
   // ****************************************
   a_acc_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !in_init |=> state_reg.acc == $past(state_reg.acc))
      else $error("acceptance written");

   a_acc_write_take: assert property (@(posedge pclk) disable iff (!presetn)
      (access && pwrite && acc_hit && in_init) |=> state_reg.acc[7:3] == $past(pwdata[7:3]))
      else $error("acceptance write lost");

   a_acc_idle_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !access |=> state_reg.acc == $past(state_reg.acc))
      else $error("acceptance changed without a write");

   a_acc_read_any: assert property (@(posedge pclk) disable iff (!presetn)
      (access && acc_hit) |-> !pslverr)
      else $error("acceptance access refused");

   a_acc_read_value: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && acc_hit) |-> prdata[7:3] == state_reg.acc[7:3])
      else $error("acceptance readback wrong");

   a_acc_hit_ro: assert property (@(posedge pclk) disable iff (!presetn)
      state_reg.acc[2:0] == 3'h0)
      else $error("hit bits stored");

   a_acc_hit_read: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && acc_hit) |-> prdata[2:0] == $past(filter_hit_in))
      else $error("hit bits readback wrong");

   a_acc_hit_out: assert property (@(posedge pclk) disable iff (!presetn)
      acceptance_control[2:0] == filter_hit_in)
      else $error("hit bits output wrong");

   // ****************************************
   // Checks on flags and bus
   // ****************************************
   a_empty_flag: assert property (@(posedge pclk) disable iff (!presetn)
      buffer_empty_flag == buf_free)
      else $error("empty flag mismatch");

   a_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pwrite && flag_hit) |-> prdata[2:0] == $past(buf_free) && !pslverr)
      else $error("flag readback wrong");

   a_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !access |-> !pslverr)
      else $error("error outside access");
endmodule : cxbs_top

// >>> bench/can_xmit_buffer_select_tb_top.sv
// Self-checking bench for the transmit buffer select block
`timescale 1ns/1ps
module can_xmit_buffer_select_tb_top;
   // ********
   // Signals
   // ********
   localparam logic [7:0] SEL = cxbs_pkg::ADDR_SELECTOR;
   localparam logic [7:0] ACC = cxbs_pkg::ADDR_ACC_CTRL;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        init_request = 0, init_acknowledge = 0, pready, pslverr, err;
   event        done_e;
   logic [7:0]  paddr = 8'h00, acceptance_control;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0]  buf_free = 3'h0, buf_scheduled = 3'h0, filter_hit_in = 3'h0;
   logic [2:0]  buffer_empty_flag, fg_select;
   int          errors = 0, total_checks = 0, cycles = 0;
   cxbs_top cxbs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .init_request(init_request), .init_acknowledge(init_acknowledge),
      .buf_free(buf_free), .buf_scheduled(buf_scheduled), .filter_hit_in(filter_hit_in),
      .buffer_empty_flag(buffer_empty_flag), .fg_select(fg_select),
      .acceptance_control(acceptance_control));
   initial begin
      forever #12.5 pclk = ~pclk;
   end
   // Answer taken at the completing edge, timeout count
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (psel && penable && pready) begin
         rd = prdata;
         err = pslverr;
         -> done_e;
      end
      if (cycles == 3000) begin
         errors++;
         close_out();
      end
   end
   // ********
   // Tasks
   // ********
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(done_e);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0);
      chk("read data", e, rd);
      chk("error", {31'h0, ee}, {31'h0, err});
   endtask : rdc
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out
   // ********
   // Tests
   // ********
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdc(SEL, 32'h0, 1'b0);
      rdc(8'h20, 32'h0, 1'b1);
      rdc(8'h40, 32'h0, 1'b1);
      $display("test reset done");
      @(posedge pclk);
      buf_free <= 3'h6;
      rdc(cxbs_pkg::ADDR_FLAGS, 32'h6, 1'b0);
      chk("empty flag", 32'h6, {29'h0, buffer_empty_flag});
      apb(1'b1, SEL, 32'h6);
      rdc(SEL, 32'h2, 1'b0);
      chk("select", 32'h2, {29'h0, fg_select});
      apb(1'b1, 8'h44, 32'hA5A51234);
      chk("write error", 32'h0, {31'h0, err});
      apb(1'b1, SEL, 32'h7);
      rdc(SEL, 32'h1, 1'b0);
      rdc(8'h44, 32'h0, 1'b0);
      $display("test select done");
      apb(1'b1, SEL, 32'h2);
      @(posedge pclk);
      buf_free <= 3'h5;
      buf_scheduled <= 3'h2;
      apb(1'b1, 8'h44, 32'h0000FFFF);
      chk("write error", 32'h1, {31'h0, err});
      rdc(8'h44, 32'h0, 1'b1);
      @(posedge pclk);
      buf_scheduled <= 3'h0;
      rdc(8'h44, 32'hA5A51234, 1'b0);
      $display("test blocking done");
      @(posedge pclk);
      init_request <= 1'b1;
      init_acknowledge <= 1'b1;
      filter_hit_in <= 3'h5;
      apb(1'b1, ACC, 32'hFF);
      rdc(ACC, 32'hFD, 1'b0);
      chk("acceptance", 32'hFD, {24'h0, acceptance_control});
      apb(1'b1, SEL, 32'h1);
      rdc(SEL, 32'h0, 1'b0);
      rdc(8'h40, 32'h0, 1'b1);
      @(posedge pclk);
      init_acknowledge <= 1'b0;
      apb(1'b1, SEL, 32'h4);
      rdc(SEL, 32'h0, 1'b0);
      apb(1'b1, ACC, 32'h0);
      rdc(ACC, 32'hFD, 1'b0);
      @(posedge pclk);
      init_request <= 1'b0;
      apb(1'b1, SEL, 32'h4);
      rdc(SEL, 32'h4, 1'b0);
      $display("test init done");
      close_out();
   end
endmodule : can_xmit_buffer_select_tb_top
